/* sods_pkg.sv */
// Package for the speaker output diagnostic sequencer
package sods_pkg;
    localparam int CLK_HZ = 125000000;
    localparam int CLK_PERIOD_NS = 8;
    // Time figures in their own units
    localparam int RECHECK_MS = 1;
    localparam int ACQ_MS = 100;
    localparam int SAFETY_MS = 40;
    // Cycle counts derived from the clock rate
    localparam int RECHECK_CYC = RECHECK_MS * (CLK_HZ / 1000);
    localparam int ACQ_CYC = ACQ_MS * (CLK_HZ / 1000);
    localparam int SAFETY_CYC = SAFETY_MS * (CLK_HZ / 1000);
    // Control and status byte bit positions
    localparam int CB1_OFFSET_EN_BIT = 5;
    localparam int CB2_SAFETY_EN_BIT = 0;
    localparam int CB2_AC_EN_BIT = 2;
    localparam int CB2_AC_LOWTHR_BIT = 7;
    localparam int SB2_SAFETY_OFF_BIT = 6;
    localparam int AC_PULSES_MIN = 3;
    localparam int NCH = 4;
    localparam int CW = 24;
    localparam logic [CW-1:0] CNT_ZERO = 24'h000000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // Turn-on sequencer states
    typedef enum logic [3:0] {
        SODS_TO_IDLE = 4'h1,
        SODS_TO_PULSE = 4'h2,
        SODS_TO_BIASED = 4'h4,
        SODS_TO_DONE = 4'h8
    } sods_ton_t;

    // Permanent diagnostic per-channel states
    typedef enum logic [3:0] {
        SODS_CH_ACTIVE = 4'h1,
        SODS_CH_RECHECK = 4'h2,
        SODS_CH_DIAG = 4'h4,
        SODS_CH_RESTART = 4'h8
    } sods_ch_t;

    // Analog fault sense for one channel, from the link side
    typedef struct packed {
        logic overload;
        logic shortGnd;
        logic shortVs;
        logic shortLoad;
        logic openLoad;
        logic offsetHigh;
        logic acPeak;
    } sods_sense_t;

    // Fault result for one channel
    typedef struct packed {
        logic shortGnd;
        logic shortVs;
        logic shortLoad;
        logic openLoad;
        logic lineClass;
    } sods_res_t;

    // Counter expired test, shared by the timed state machines
    function automatic logic cntDone(input logic [CW-1:0] c, input int lim);
        cntDone = (c >= lim[CW-1:0] - 24'h000001);
    endfunction

    // All state of the sequencer
    typedef struct packed {
        sods_ton_t ton;
        logic [CW-1:0] tonCnt;
        logic tonReadSeen;
        logic prevDiag;
        sods_ch_t [NCH-1:0] ch;
        logic [NCH-1:0][CW-1:0] chCnt;
        logic [NCH-1:0] cycleArmed;
        logic [NCH-1:0][1:0] acPulses;
        logic [NCH-1:0] acAbort;
        logic [NCH-1:0] acPrev;
        logic acThrLow;
        logic [NCH-1:0] offPersist;
        logic [NCH-1:0] offAbort;
        logic prevOffEn;
        logic prevPlay;
        logic safetyArmed;
        logic [CW-1:0] safetyCnt;
        logic safetyOff;
        logic stageOff;
        logic [NCH-1:0] chEnable;
        logic [NCH-1:0] testPulse;
        logic ampBiased;
        logic ampMute;
        sods_res_t [NCH-1:0] turnOnResult;
        sods_res_t [NCH-1:0] permPending;
        sods_res_t [NCH-1:0] permResult;
        logic [NCH-1:0] acOpen;
        logic [NCH-1:0] offsetFault;
    } sods_state_t;
endpackage

/* sods_sequencer.sv */
// Speaker output diagnostic sequencer: turn-on, permanent, AC and offset diagnostics
// Contract
// - Turn-on result is held until a new pulse, requested only after a read.
// - Standby-out with diag enable together runs the pulse first, stage off.
// - After biasing, permanent diagnostics run; turn-on result kept until a short.
// - Output status latched at plateau end; acquisition lasts 100 ms.
// - Line-driver load class only with 16 dB gain and line diag set.
// - Diagnostics off: only the shorted channel shuts down, others run.
// - Restart mode rechecks a faulted output every 1 ms, re-enables when clear.
// - Diagnostic mode on short protection, only with host diag enable set.
// - Overload trigger rechecked 1 ms later; if gone, channel returns active.
// - Persisting overload starts a 100 ms diagnostic cycle on that channel.
// - After a cycle: restart mode, data stored, next cycle only after read.
// - Control byte two bit 2 enables AC diagnostic on peak current.
// - Control byte two bit 7 selects high or low AC current threshold.
// - Tweeter present only with at least 3 peak pulses, else open flagged.
// - Short protection during measurement abandons AC and offset detection.
// - Safety routine mutes the amplifier within 40 ms on offset after play.
// - Safety routine enabled only by control byte two bit 0.
// - Safety shutdown shown in status byte two bit 6; standby clears it.
// - Offset measured from previous read or enable to read; must persist.
// - A read returns the previous cycle's result and restarts the cycle.
`timescale 1ns/10ps
module sods_sequencer
    import sods_pkg::*;
#(
    parameter int RECHECK_CYCLES = RECHECK_CYC,
    parameter int ACQ_CYCLES = ACQ_CYC,
    parameter int SAFETY_CYCLES = SAFETY_CYC
)(
    input wire logic clk,
    input wire logic srst,
    input wire logic linkClk,
    input wire logic [7:0] controlByteOne,
    input wire logic [7:0] controlByteTwo,
    input wire logic standbyReq,
    input wire logic standbyMutePin_n,
    input wire logic diagEnable,
    input wire logic lowGain,
    input wire logic lineDiagSel,
    input wire logic playCmd,
    input wire logic readStrobe,
    input wire sods_sense_t [NCH-1:0] senseLink,
    output logic stageOff,
    output logic [NCH-1:0] chEnable,
    output logic [NCH-1:0] testPulse,
    output logic ampBiased,
    output logic ampMute,
    output sods_res_t [NCH-1:0] turnOnResult,
    output sods_res_t [NCH-1:0] permResult,
    output logic [NCH-1:0] acOpen,
    output logic [NCH-1:0] offsetFault,
    output logic [7:0] statusByteTwo
);
    // Link side: sample the analog sense on the link clock, then cross as a level
    sods_sense_t [NCH-1:0] linkCap;
    always_ff @(posedge linkClk)
        linkCap <= senseLink;
    // Two-stage synchroniser into clk, each bit is a slow independent level
    sods_sense_t [NCH-1:0] syncA;
    sods_sense_t [NCH-1:0] sen;
    always_ff @(posedge clk)
    begin
        syncA <= linkCap;
        sen <= syncA;
    end
    // The standby-mute pin passes two flip-flops too
    logic [1:0] stbyPinSync;
    always_ff @(posedge clk)
        stbyPinSync <= {stbyPinSync[0], standbyMutePin_n};

    // All block state, one packed struct
    sods_state_t s;
    sods_state_t next_s;
    logic standbyAny;
    // Standby from command or hardware pin
    assign standbyAny = standbyReq | ~stbyPinSync[1];
    // Next-state logic for every diagnostic function
    always_comb
    begin
        logic lineMode;
        logic anyShort;
        sods_res_t r;
        lineMode = 1'b0;
        anyShort = 1'b0;
        r = '0;
        next_s = s;
        lineMode = lowGain & lineDiagSel;
        for (int i = 0; i < NCH; i++)
        begin
            anyShort = anyShort | sen[i].shortGnd | sen[i].shortVs | sen[i].shortLoad;
        end
        if (readStrobe)
            next_s.tonReadSeen = 1'b1;
        next_s.prevDiag = diagEnable;
        // Turn-on sequencer
        case (s.ton)
            SODS_TO_IDLE:
            begin
                next_s.ampBiased = 1'b0;
                next_s.chEnable = '0;
                if (!standbyAny && diagEnable && (s.tonReadSeen || !s.prevDiag))
                begin
                    next_s.ton = SODS_TO_PULSE;
                    next_s.stageOff = 1'b1;
                    next_s.testPulse = '1;
                    next_s.tonCnt = CNT_ZERO;
                end
                else if (!standbyAny)
                begin
                    next_s.ton = SODS_TO_BIASED;
                    next_s.stageOff = 1'b0;
                    next_s.ampBiased = 1'b1;
                    next_s.chEnable = '1;
                end
            end
            SODS_TO_PULSE:
            begin
                next_s.tonCnt = s.tonCnt + 24'h000001;
                if (cntDone(s.tonCnt, ACQ_CYCLES))
                begin
                    // Latch at the end of the plateau
                    for (int i = 0; i < NCH; i++)
                    begin
                        r.shortGnd = sen[i].shortGnd;
                        r.shortVs = sen[i].shortVs;
                        r.shortLoad = sen[i].shortLoad;
                        r.openLoad = sen[i].openLoad;
                        r.lineClass = lineMode;
                        next_s.turnOnResult[i] = r;
                    end
                    next_s.testPulse = '0;
                    next_s.stageOff = 1'b0;
                    next_s.ampBiased = 1'b1;
                    next_s.chEnable = '1;
                    next_s.tonReadSeen = 1'b0;
                    next_s.ton = SODS_TO_DONE;
                end
            end
            SODS_TO_DONE:
            begin
                // Result held until read and a new request, or a short appears
                if (anyShort)
                begin
                    next_s.turnOnResult = '0;
                    next_s.ton = SODS_TO_BIASED;
                end
                else if (s.tonReadSeen && diagEnable && !s.prevDiag)
                begin
                    next_s.ton = SODS_TO_IDLE;
                end
            end
            SODS_TO_BIASED:
            begin
                if (s.tonReadSeen && diagEnable && !s.prevDiag)
                begin
                    next_s.ton = SODS_TO_IDLE;
                end
            end
            default:
            begin
                next_s.ton = SODS_TO_IDLE;
            end
        endcase
        // Permanent diagnostics per channel, once biased
        for (int i = 0; i < NCH; i++)
        begin
            next_s.chCnt[i] = s.chCnt[i] + 24'h000001;
            if (readStrobe)
                next_s.cycleArmed[i] = 1'b1;
            case (s.ch[i])
                SODS_CH_ACTIVE:
                begin
                    if (s.ampBiased && sen[i].overload)
                    begin
                        next_s.chEnable[i] = 1'b0;
                        next_s.chCnt[i] = CNT_ZERO;
                        if (diagEnable && s.cycleArmed[i])
                        begin
                            next_s.ch[i] = SODS_CH_RECHECK;
                        end
                        else
                        begin
                            next_s.ch[i] = SODS_CH_RESTART;
                        end
                    end
                end
                SODS_CH_RECHECK:
                begin
                    if (cntDone(s.chCnt[i], RECHECK_CYCLES))
                    begin
                        next_s.chCnt[i] = CNT_ZERO;
                        if (!sen[i].overload)
                        begin
                            next_s.ch[i] = SODS_CH_ACTIVE;
                            next_s.chEnable[i] = 1'b1;
                        end
                        else
                        begin
                            next_s.ch[i] = SODS_CH_DIAG;
                        end
                    end
                end
                SODS_CH_DIAG:
                begin
                    if (cntDone(s.chCnt[i], ACQ_CYCLES))
                    begin
                        r.shortGnd = sen[i].shortGnd;
                        r.shortVs = sen[i].shortVs;
                        r.shortLoad = sen[i].shortLoad;
                        r.openLoad = 1'b0;
                        r.lineClass = lineMode;
                        next_s.permPending[i] = r;
                        next_s.cycleArmed[i] = readStrobe;
                        next_s.chCnt[i] = CNT_ZERO;
                        next_s.ch[i] = SODS_CH_RESTART;
                    end
                end
                SODS_CH_RESTART:
                begin
                    if (cntDone(s.chCnt[i], RECHECK_CYCLES))
                    begin
                        next_s.chCnt[i] = CNT_ZERO;
                        if (!sen[i].overload)
                        begin
                            next_s.ch[i] = SODS_CH_ACTIVE;
                            next_s.chEnable[i] = 1'b1;
                        end
                    end
                end
                default:
                begin
                    next_s.ch[i] = SODS_CH_ACTIVE;
                end
            endcase
        end
        // AC tweeter detection, counting rising edges of the peak comparator
        for (int i = 0; i < NCH; i++)
        begin
            next_s.acPrev[i] = sen[i].acPeak;
            if (sen[i].overload)
            begin
                next_s.acAbort[i] = 1'b1;
                next_s.offAbort[i] = 1'b1;
            end
            if (controlByteTwo[CB2_AC_EN_BIT] && sen[i].acPeak && !s.acPrev[i]
                && s.acPulses[i] != 2'(AC_PULSES_MIN))
            begin
                next_s.acPulses[i] = s.acPulses[i] + 2'h1;
            end
            // Normal-operation offset must persist over the whole window
            if (!sen[i].offsetHigh)
                next_s.offPersist[i] = 1'b0;
        end
        // Pulses judged at the old threshold level are void after a change
        next_s.acThrLow = controlByteTwo[CB2_AC_LOWTHR_BIT];
        if (controlByteTwo[CB2_AC_LOWTHR_BIT] != s.acThrLow)
            next_s.acPulses = '0;
        next_s.prevOffEn = controlByteOne[CB1_OFFSET_EN_BIT];
        if (controlByteOne[CB1_OFFSET_EN_BIT] && !s.prevOffEn)
        begin
            next_s.offPersist = '1;
            next_s.offAbort = '0;
        end
        // A read publishes the finished window and starts a new one
        if (readStrobe)
        begin
            next_s.permResult = s.permPending;
            for (int i = 0; i < NCH; i++)
            begin
                next_s.acOpen[i] = controlByteTwo[CB2_AC_EN_BIT] && !s.acAbort[i]
                    && (s.acPulses[i] < 2'(AC_PULSES_MIN));
                next_s.offsetFault[i] = controlByteOne[CB1_OFFSET_EN_BIT]
                    && s.offPersist[i] && !s.offAbort[i];
                // An overload on the read edge still spoils the new window
                next_s.acAbort[i] = sen[i].overload;
                next_s.offAbort[i] = sen[i].overload;
            end
            next_s.acPulses = '0;
            next_s.offPersist = '1;
        end
        // Start-up safety routine
        next_s.prevPlay = playCmd;
        next_s.ampMute = !playCmd || s.safetyOff;
        if (playCmd && !s.prevPlay && controlByteTwo[CB2_SAFETY_EN_BIT])
        begin
            next_s.safetyArmed = 1'b1;
            next_s.safetyCnt = CNT_ZERO;
        end
        if (s.safetyArmed)
        begin
            next_s.safetyCnt = s.safetyCnt + 24'h000001;
            for (int i = 0; i < NCH; i++)
            begin
                if (sen[i].offsetHigh)
                begin
                    next_s.safetyOff = 1'b1;
                end
            end
            if (cntDone(s.safetyCnt, SAFETY_CYCLES))
            begin
                next_s.safetyArmed = 1'b0;
            end
        end
        if (s.safetyOff)
        begin
            next_s.chEnable = '0;
            next_s.ampMute = 1'b1;
        end
        // Standby resets the amplifier and clears the shutdown
        if (standbyAny)
        begin
            next_s.safetyOff = 1'b0;
            next_s.safetyArmed = 1'b0;
            next_s.ton = SODS_TO_IDLE;
            next_s.ampBiased = 1'b0;
            next_s.chEnable = '0;
            next_s.testPulse = '0;
            next_s.stageOff = 1'b1;
            for (int i = 0; i < NCH; i++)
            begin
                next_s.ch[i] = SODS_CH_ACTIVE;
            end
        end
    end
    // State register
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            s <= '0;
            s.ton <= SODS_TO_IDLE;
            s.ch <= {NCH{SODS_CH_ACTIVE}};
            s.cycleArmed <= '1;
            s.offPersist <= '1;
            s.stageOff <= 1'b1;
            s.ampMute <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end
    assign stageOff = s.stageOff;
    assign chEnable = s.chEnable;
    assign testPulse = s.testPulse;
    assign ampBiased = s.ampBiased;
    assign ampMute = s.ampMute;
    assign turnOnResult = s.turnOnResult;
    assign permResult = s.permResult;
    assign acOpen = s.acOpen;
    assign offsetFault = s.offsetFault;
    assign statusByteTwo = {1'h0, s.safetyOff, 6'h00};
    // Checks
    property p_pulse_off;
        @(posedge clk) disable iff (srst) (|s.testPulse) |-> s.stageOff;
    endproperty
    a_pulse_off: assert property (p_pulse_off) else $error("pulse without stage off");
    property p_pulse_first;
        @(posedge clk) disable iff (srst)
            (s.ton == SODS_TO_IDLE && next_s.ton == SODS_TO_PULSE) |=> !s.ampBiased;
    endproperty
    a_pulse_first: assert property (p_pulse_first) else $error("biased during pulse");
    property p_safety_mute;
        @(posedge clk) disable iff (srst) s.safetyOff |=> (s.chEnable == '0) && s.ampMute;
    endproperty
    a_safety_mute: assert property (p_safety_mute) else $error("safety did not mute");
    property p_safety_en;
        @(posedge clk) disable iff (srst)
            $rose(s.safetyArmed) |-> $past(controlByteTwo[CB2_SAFETY_EN_BIT]);
    endproperty
    a_safety_en: assert property (p_safety_en) else $error("safety armed while off");
    property p_status_bit;
        @(posedge clk) disable iff (srst)
            $rose(statusByteTwo[SB2_SAFETY_OFF_BIT]) |-> $past(s.safetyArmed);
    endproperty
    a_status_bit: assert property (p_status_bit) else $error("status bit mismatch");
    property p_read_pub;
        @(posedge clk) disable iff (srst) readStrobe |=> s.permResult == $past(s.permPending);
    endproperty
    a_read_pub: assert property (p_read_pub) else $error("read did not publish");
    logic anyShortHelper;
    assign anyShortHelper = s.ton == SODS_TO_DONE;
    property p_line_class;
        @(posedge clk) disable iff (srst)
            $changed(s.turnOnResult) && !$past(anyShortHelper) |->
            s.turnOnResult[0].lineClass == $past(lowGain & lineDiagSel);
    endproperty
    a_line_class: assert property (p_line_class) else $error("line class wrong");
    property p_restart_wait;
        @(posedge clk) disable iff (srst || standbyAny)
            (s.ch[0] == SODS_CH_RESTART && next_s.ch[0] == SODS_CH_ACTIVE)
            |-> s.chCnt[0] == 24'(RECHECK_CYCLES - 1);
    endproperty
    a_restart_wait: assert property (p_restart_wait) else $error("restart period wrong");
endmodule

/* sods_sense_model.sv */
// Analog sense partner model on the link clock
`timescale 1ns/10ps
module sods_sense_model
    import sods_pkg::*;
(
    input wire logic linkClk,
    input wire sods_sense_t [NCH-1:0] faultReq,
    output sods_sense_t [NCH-1:0] senseLink
);
    // Sense bits move only on link clock edges, never between them
    always_ff @(posedge linkClk)
    begin
        senseLink <= faultReq;
    end
endmodule

/* sods_sequencer_bench.sv */
// Self-checking bench for the speaker output diagnostic sequencer
`timescale 1ns/10ps
module sods_sequencer_bench
    import sods_pkg::*;
;
    localparam int RCY = 20;
    localparam int ACY = 50;
    localparam int SCY = 30;
    logic clk, linkClk, srst, standbyReq, standbyMutePin_n, diagEnable;
    logic lowGain, lineDiagSel, playCmd, readStrobe, stageOff, ampBiased, ampMute;
    logic [7:0] controlByteOne, controlByteTwo, statusByteTwo;
    logic [NCH-1:0] chEnable, testPulse, acOpen, offsetFault;
    sods_sense_t [NCH-1:0] faultReq, senseLink;
    sods_res_t [NCH-1:0] turnOnResult, permResult;
    int errorCnt = 0;
    int numChecks = 0;
    int n;

    // Far-side sense source and the design
    sods_sense_model model (.linkClk(linkClk), .faultReq(faultReq), .senseLink(senseLink));
    sods_sequencer #(.RECHECK_CYCLES(RCY), .ACQ_CYCLES(ACY), .SAFETY_CYCLES(SCY)) dut (
        .clk(clk), .srst(srst), .linkClk(linkClk), .controlByteOne(controlByteOne),
        .controlByteTwo(controlByteTwo), .standbyReq(standbyReq),
        .standbyMutePin_n(standbyMutePin_n), .diagEnable(diagEnable), .lowGain(lowGain),
        .lineDiagSel(lineDiagSel), .playCmd(playCmd), .readStrobe(readStrobe),
        .senseLink(senseLink), .stageOff(stageOff), .chEnable(chEnable),
        .testPulse(testPulse), .ampBiased(ampBiased), .ampMute(ampMute),
        .turnOnResult(turnOnResult), .permResult(permResult), .acOpen(acOpen),
        .offsetFault(offsetFault), .statusByteTwo(statusByteTwo));

    // Clocks, unrelated in phase
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial
    begin
        linkClk = 1'b0;
        #1.3;
        forever #3 linkClk = ~linkClk;
    end

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp)
        begin
            errorCnt++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Advance k cycles, land just after the edge
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // One-cycle status read, as the host's bus read
    task automatic rd;
        readStrobe = 1'b1;
        cyc(1);
        readStrobe = 1'b0;
        cyc(1);
    endtask

    // Bounded wait for one channel enable to reach a level
    task automatic waitCh(input int i, input logic v, input int lim);
        n = 0;
        while (chEnable[i] !== v && n < lim)
        begin
            cyc(1);
            n++;
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", numChecks, errorCnt);
        if (errorCnt == 0 && numChecks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Watchdog well beyond the expected run
    initial
    begin
        #200000;
        errorCnt++;
        $display("watchdog expired");
        end_of_test;
    end

    // Test sequence
    initial
    begin
        srst = 1'b1;
        standbyReq = 1'b1;
        standbyMutePin_n = 1'b1;
        diagEnable = 1'b0;
        lowGain = 1'b0;
        lineDiagSel = 1'b0;
        playCmd = 1'b0;
        readStrobe = 1'b0;
        controlByteOne = 8'h00;
        controlByteTwo = 8'h00;
        faultReq = '0;
        cyc(10);
        srst = 1'b0;
        check(stageOff, 1);
        check(ampMute, 1);
        check(chEnable, 4'h0);
        $display("test reset done");
        // Turn-on pulse with standby out in the same step
        faultReq[2].openLoad = 1'b1;
        cyc(4);
        standbyReq = 1'b0;
        diagEnable = 1'b1;
        cyc(1);
        check(stageOff, 1);
        check(testPulse, 4'hF);
        cyc(ACY - 1);
        check(testPulse, 4'hF);
        cyc(1);
        check(testPulse, 4'h0);
        check(ampBiased, 1);
        check(chEnable, 4'hF);
        check(turnOnResult[2].openLoad, 1);
        check(turnOnResult[0].lineClass, 0);
        faultReq[2].openLoad = 1'b0;
        // New pulse refused until a read
        diagEnable = 1'b0;
        cyc(2);
        diagEnable = 1'b1;
        cyc(2);
        check(testPulse, 4'h0);
        check(turnOnResult[2].openLoad, 1);
        diagEnable = 1'b0;
        rd;
        lowGain = 1'b1;
        lineDiagSel = 1'b1;
        diagEnable = 1'b1;
        // From the held result the sequencer passes idle before the new pulse
        cyc(2);
        check(testPulse, 4'hF);
        cyc(ACY + 2);
        check(turnOnResult[0].lineClass, 1);
        check(turnOnResult[2].openLoad, 0);
        lowGain = 1'b0;
        lineDiagSel = 1'b0;
        $display("test turn-on done");
        // Transient overload: recheck finds it gone
        rd;
        faultReq[0].overload = 1'b1;
        waitCh(0, 1'b0, 10);
        check(chEnable, 4'hE);
        faultReq[0].overload = 1'b0;
        cyc(RCY - 4);
        check(chEnable[0], 0);
        waitCh(0, 1'b1, 12);
        check(chEnable, 4'hF);
        // Persistent short: diagnostic cycle, then restart
        faultReq[3].overload = 1'b1;
        faultReq[3].shortGnd = 1'b1;
        waitCh(3, 1'b0, 10);
        check(chEnable, 4'h7);
        cyc(RCY + ACY + 10);
        rd;
        check(permResult[3].shortGnd, 1);
        check(chEnable[3], 0);
        faultReq[3] = '0;
        waitCh(3, 1'b1, RCY + 10);
        check(chEnable, 4'hF);
        $display("test permanent done");
        // Tweeter presence at both thresholds
        for (int t = 0; t < 2; t++)
        begin
            controlByteTwo = (t == 0) ? 8'h04 : 8'h84;
            rd;
            for (int k = 0; k < 3; k++)
            begin
                faultReq[0].acPeak = 1'b1;
                faultReq[1].acPeak = (k < 2);
                cyc(3);
                faultReq[0].acPeak = 1'b0;
                faultReq[1].acPeak = 1'b0;
                cyc(3);
            end
            rd;
            check(acOpen, 4'hE);
        end
        // Short protection during the window abandons the result
        faultReq[2].overload = 1'b1;
        cyc(5);
        faultReq[2].overload = 1'b0;
        rd;
        check(acOpen[2], 0);
        controlByteTwo = 8'h00;
        cyc(RCY + 10);
        $display("test tweeter done");
        // Offset window from enable to read
        faultReq[3].offsetHigh = 1'b1;
        faultReq[2].offsetHigh = 1'b1;
        cyc(5);
        controlByteOne = 8'h20;
        cyc(10);
        faultReq[2].offsetHigh = 1'b0;
        cyc(10);
        rd;
        check(offsetFault, 4'h8);
        faultReq[3].offsetHigh = 1'b0;
        controlByteOne = 8'h00;
        $display("test offset done");
        // Safety mute only when enabled, cleared by the standby pin
        faultReq[0].offsetHigh = 1'b1;
        cyc(5);
        playCmd = 1'b1;
        cyc(SCY + 5);
        check(statusByteTwo, 8'h00);
        check(ampMute, 0);
        playCmd = 1'b0;
        controlByteTwo = 8'h01;
        cyc(2);
        playCmd = 1'b1;
        cyc(SCY);
        check(ampMute, 1);
        check(statusByteTwo, 8'h40);
        standbyMutePin_n = 1'b0;
        cyc(5);
        check(statusByteTwo, 8'h00);
        $display("test safety done");
        end_of_test;
    end
endmodule
